// >>> core/sapcc_top.sv
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
// sapcc_top: apb-controlled serial audio port with input clock validity checking
module sapcc_top
    import sapcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_proc,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] bit_clock_i,
    input wire logic [2:0] frame_clock_i,
    input wire logic [1:0] serial_data_in,
    output sapcc_pins_t pins_o,
    output logic [SAPCC_NCH-1:0] mute_ch
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic sapcc_hit(input logic [7:0] a);
        return a inside {SAPCC_IN1_EFC, SAPCC_IN2_EFC, SAPCC_OUT_EFC, SAPCC_IN1_RATIO,
            SAPCC_IN2_RATIO, SAPCC_OUT_RATIO, SAPCC_VALID_CFG, SAPCC_MODE, SAPCC_MAP,
            SAPCC_TX_LEFT, SAPCC_TX_RIGHT, SAPCC_STATUS, SAPCC_RX1_LEFT, SAPCC_RX1_RIGHT,
            SAPCC_RX2_LEFT, SAPCC_RX2_RIGHT};
    endfunction : sapcc_hit

    function automatic logic [7:0] sapcc_wlen(input logic [1:0] c);
        return {3'h0, c, 3'h0} + SAPCC_WL_STEP;
    endfunction : sapcc_wlen

    function automatic logic [31:0] sapcc_mask(input logic [7:0] w);
        return 32'hFFFF_FFFF >> (SAPCC_MAXW - w[5:0]);
    endfunction : sapcc_mask

    sapcc_st_t r_reg, r_next;
    sapcc_pst_t q_reg, q_next;
    logic [2:0] act_v, stb_v, fs_v;
    logic [1:0] err_v;

    // ------------------------------------------------------------
    // bus side and serial ports, pclk domain
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0] fmt;
        logic [7:0] wl, gnext, npos, dly;
        logic lvl, lr, rj, i2s, start, chan;
        logic [31:0] word;
        fmt = '0;
        wl = '0;
        gnext = '0;
        npos = '0;
        dly = '0;
        lvl = 1'b0;
        lr = 1'b0;
        rj = 1'b0;
        i2s = 1'b0;
        start = 1'b0;
        chan = 1'b0;
        word = '0;
        r_next = r_reg;
        act_v = '0;
        stb_v = '0;
        fs_v = '0;
        r_next.pready = 1'b0;
        case (r_reg.fsm)
            SAPCC_IDLE: begin
                if (psel && penable) begin
                    r_next.fsm = SAPCC_DONE;
                    r_next.pready = 1'b1;
                    r_next.pslverr = !sapcc_hit(paddr);
                    case (paddr)
                        SAPCC_IN1_EFC: r_next.prdata = 32'(r_reg.cfg[0]);
                        SAPCC_IN2_EFC: r_next.prdata = 32'(r_reg.cfg[1]);
                        SAPCC_OUT_EFC: r_next.prdata = 32'(r_reg.cfg[2]);
                        SAPCC_IN1_RATIO: r_next.prdata = 32'(r_reg.ratio[0]);
                        SAPCC_IN2_RATIO: r_next.prdata = 32'(r_reg.ratio[1]);
                        SAPCC_OUT_RATIO: r_next.prdata = 32'(r_reg.ratio[2]);
                        SAPCC_VALID_CFG: r_next.prdata = 32'(r_reg.valid);
                        SAPCC_MODE: r_next.prdata = 32'({r_reg.div, 7'h00, r_reg.master});
                        SAPCC_MAP: r_next.prdata = 32'(r_reg.map);
                        SAPCC_TX_LEFT: r_next.prdata = r_reg.txl;
                        SAPCC_TX_RIGHT: r_next.prdata = r_reg.txr;
                        SAPCC_STATUS: begin
                            r_next.prdata = 32'({r_reg.mute, r_reg.ms2, r_reg.p[1].rerr, r_reg.p[0].rerr}); // RULE16
                        end
                        SAPCC_RX1_LEFT: r_next.prdata = r_reg.p[0].left;
                        SAPCC_RX1_RIGHT: r_next.prdata = r_reg.p[0].right;
                        SAPCC_RX2_LEFT: r_next.prdata = r_reg.p[1].left;
                        SAPCC_RX2_RIGHT: r_next.prdata = r_reg.p[1].right;
                        default: r_next.prdata = '0;
                    endcase
                end
            end
            SAPCC_DONE: begin
                // write lands on the edge that also samples pready high
                r_next.fsm = SAPCC_IDLE;
                r_next.prdata = '0;
                r_next.pslverr = 1'b0;
                if (pwrite && sapcc_hit(paddr)) begin
                    case (paddr)
                        SAPCC_IN1_EFC: r_next.cfg[0] = 8'(pwdata);
                        SAPCC_IN2_EFC: r_next.cfg[1] = 8'(pwdata);
                        SAPCC_OUT_EFC: r_next.cfg[2] = 8'(pwdata);
                        SAPCC_IN1_RATIO: r_next.ratio[0] = 8'(pwdata);
                        SAPCC_IN2_RATIO: r_next.ratio[1] = 8'(pwdata);
                        SAPCC_OUT_RATIO: r_next.ratio[2] = 8'(pwdata);
                        SAPCC_VALID_CFG: r_next.valid = 3'(pwdata);
                        SAPCC_MODE: begin
                            r_next.master = pwdata[0];
                            r_next.div = pwdata[SAPCC_MODE_DIV_LSB +: 8];
                        end
                        SAPCC_MAP: r_next.map = sapcc_map_t'(pwdata[2*SAPCC_NCH-1:0]);
                        SAPCC_TX_LEFT: r_next.txl = pwdata;
                        SAPCC_TX_RIGHT: r_next.txr = pwdata;
                        default: ;
                    endcase
                end
            end
            default: r_next.fsm = SAPCC_IDLE;
        endcase

        for (int i = 0; i < 3; i++) begin
            r_next.p[i].b_s1 = bit_clock_i[i];
            r_next.p[i].b_s2 = r_reg.p[i].b_s1;
            r_next.p[i].f_s1 = frame_clock_i[i];
            r_next.p[i].f_s2 = r_reg.p[i].f_s1;
            r_next.p[i].d_s1 = (i < 2) ? serial_data_in[i % 2] : 1'b0;
            r_next.p[i].d_s2 = r_reg.p[i].d_s1;
            // each port owns its divider counter, but all compare against the shared div, so master bit clocks run at one rate
            r_next.p[i].gdiv = r_reg.p[i].gdiv + 8'h01; // RULE4
            if (r_reg.p[i].gdiv >= r_reg.div) begin
                r_next.p[i].gdiv = '0;
                r_next.p[i].gbclk = !r_reg.p[i].gbclk; // RULE5
            end
            lvl = r_reg.master ? r_reg.p[i].gbclk : r_reg.p[i].b_s2; // RULE6
            fs_v[i] = r_reg.master ? r_reg.p[i].gfrm : r_reg.p[i].f_s2;
            r_next.p[i].bq = lvl;
            act_v[i] = (lvl != r_reg.p[i].bq) && (lvl != r_reg.cfg[i][SAPCC_EDGE_BIT]); // RULE3
            stb_v[i] = (lvl != r_reg.p[i].bq) && (lvl == r_reg.cfg[i][SAPCC_EDGE_BIT]); // RULE2
            fmt = r_reg.cfg[i][SAPCC_FMT_LSB +: 3];
            wl = sapcc_wlen(r_reg.cfg[i][SAPCC_WL_LSB +: 2]); // RULE7
            lr = fmt inside {SAPCC_FMT_RJ, SAPCC_FMT_LJ, SAPCC_FMT_I2S}; // RULE8
            rj = fmt == SAPCC_FMT_RJ;
            i2s = fmt == SAPCC_FMT_I2S;
            dly = {7'h00, fmt inside {SAPCC_FMT_I2S, SAPCC_FMT_PCM_D}};
            if (act_v[i]) begin
                gnext = (r_reg.p[i].gcnt + 8'h01 >= r_reg.ratio[i]) ? 8'h00 : r_reg.p[i].gcnt + 8'h01;
                r_next.p[i].gcnt = gnext;
                r_next.p[i].gfrm = lr ? ((gnext < (r_reg.ratio[i] >> 1)) ^ i2s) : (gnext == 8'h00); // RULE1
                if (i == 2) begin
                    r_next.sdo = r_reg.p[i].sh[31]; // RULE1
                    r_next.p[i].sh = r_reg.p[i].sh << 1;
                end
            end
            if (stb_v[i]) begin
                r_next.p[i].fq = fs_v[i]; // RULE2
                start = lr ? (fs_v[i] != r_reg.p[i].fq) : (fs_v[i] && !r_reg.p[i].fq);
                npos = start ? 8'h00 : r_reg.p[i].pos + 8'h01;
                r_next.p[i].pos = npos;
                if (i == 2) begin
                    // a word is loaded at each strobe that reveals a frame clock change in lr formats; otherwise at frame start and at pos dly + wl - 1
                    if (start || (!lr && npos == dly + wl - 8'h01)) begin
                        chan = lr ? (fs_v[i] ^ i2s) : start;
                        r_next.p[i].sh = (chan ? r_reg.txl : r_reg.txr) << (SAPCC_MAXW - wl[5:0]);
                    end
                end else begin
                    r_next.p[i].sh = {r_reg.p[i].sh[30:0], r_reg.p[i].d_s2}; // RULE2
                    word = (rj ? r_reg.p[i].sh : r_next.p[i].sh) & sapcc_mask(wl);
                    if (rj ? start : (npos == dly + wl - 8'h01 ||
                            (!lr && npos == dly + wl + wl - 8'h01))) begin // RULE8
                        chan = rj ? r_reg.p[i].fq : (lr ? (fs_v[i] ^ i2s) : (npos < dly + wl));
                        if (chan) begin
                            r_next.p[i].left = word;
                        end else begin
                            r_next.p[i].right = word;
                        end
                    end
                    if (fs_v[i] && !r_reg.p[i].fq) begin
                        // one frame period closed: compare bit clocks counted in it
                        r_next.p[i].rerr = r_reg.valid[SAPCC_RATIO_EN] && (r_reg.p[i].per != r_reg.ratio[i]); // RULE12
                        r_next.p[i].per = 8'h01;
                    end else begin
                        r_next.p[i].per = r_reg.p[i].per + 8'h01;
                    end
                end
            end
            if (i == 2 || !r_reg.valid[SAPCC_RATIO_EN]) begin
                r_next.p[i].rerr = 1'b0; // RULE9
            end
        end

        r_next.ms1 = q_reg.miss;
        r_next.ms2 = r_reg.ms1;
        for (int k = 0; k < 2; k++) begin
            err_v[k] = r_reg.p[k].rerr || r_reg.ms2[k]; // RULE10
        end
        for (int c = 0; c < SAPCC_NCH; c++) begin
            // released as soon as the errors behind it clear
            r_next.mute[c] = r_reg.valid[SAPCC_MUTE_EN] && // RULE16
                ((r_reg.map[c] == SAPCC_MAP_IN1 && err_v[0]) ||
                 (r_reg.map[c] == SAPCC_MAP_IN2 && err_v[1])); // RULE11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.fsm <= SAPCC_IDLE;
            r_reg.ratio <= {3{SAPCC_RATIO_RST}};
            r_reg.div <= SAPCC_DIV_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // missing bit clock watchdogs, processing clock domain
    // ------------------------------------------------------------
    // a bit clock at a multiple of the processing clock rate aliases to a constant and looks stopped
    always_comb begin
        q_next = q_reg;
        q_next.en_s1 = r_reg.valid[SAPCC_MISS_EN]; // RULE10
        q_next.en_s2 = q_reg.en_s1;
        for (int k = 0; k < 2; k++) begin
            q_next.b_s1[k] = bit_clock_i[k]; // RULE9
            q_next.b_s2[k] = q_reg.b_s1[k];
            q_next.b_q[k] = q_reg.b_s2[k];
            if (!q_reg.en_s2 || q_reg.b_s2[k] != q_reg.b_q[k]) begin
                q_next.wd[k] = SAPCC_WD_INIT; // RULE14
                q_next.miss[k] = 1'b0; // RULE16
            end else if (q_reg.wd[k] == SAPCC_WD_ZERO) begin
                q_next.miss[k] = 1'b1; // RULE15
            end else begin
                q_next.wd[k] = q_reg.wd[k] - 8'h01; // RULE13
            end
        end
    end

    always_ff @(posedge clk_proc or negedge presetn) begin
        if (!presetn) begin
            q_reg <= '0;
            q_reg.wd <= {2{SAPCC_WD_INIT}};
        end else begin
            q_reg <= q_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign mute_ch = r_reg.mute;
    assign pins_o.serial_data_out = r_reg.sdo;
    for (genvar g = 0; g < 3; g++) begin : g_pins
        assign pins_o.bit_clock[g] = r_reg.p[g].gbclk;
        assign pins_o.frame_clock[g] = r_reg.p[g].gfrm;
        assign pins_o.bit_clock_oe[g] = r_reg.master;
        assign pins_o.frame_clock_oe[g] = r_reg.master;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tx_active_edge: assert property ($changed(r_reg.sdo) |-> $past(act_v[2])) // RULE1
        else $error("serial out changed off the active edge");
    a_rx_strobe_edge: assert property ($changed(r_reg.p[0].sh) |-> $past(stb_v[0])) // RULE2
        else $error("input shift changed off the strobe edge");
    a_edge_select: assert property (stb_v[1] |=> r_reg.p[1].bq == r_reg.cfg[1][SAPCC_EDGE_BIT]) // RULE3
        else $error("strobe edge does not follow edge select");
    a_master_clock: assert property (r_reg.master && r_reg.p[2].gdiv >= r_reg.div |=> // RULE5
        $changed(pins_o.bit_clock[2]) && pins_o.bit_clock_oe[2]) else $error("master bit clock not driven");
    a_slave_pins: assert property (!r_reg.master |-> pins_o.bit_clock_oe == 3'h0 && pins_o.frame_clock_oe == 3'h0) // RULE6
        else $error("clock pin driven in slave mode");
    a_ratio_flag: assert property (stb_v[0] && fs_v[0] && !r_reg.p[0].fq && r_reg.valid[SAPCC_RATIO_EN] // RULE12
        && r_reg.p[0].per != r_reg.ratio[0] |=> r_reg.p[0].rerr) else $error("ratio mismatch not flagged");
    a_mute_mapped: assert property (err_v[1] && r_reg.valid[SAPCC_MUTE_EN] && r_reg.map[2] == SAPCC_MAP_IN2 // RULE11
        |=> mute_ch[2]) else $error("mapped channel not muted");
    a_mute_release: assert property (err_v == 2'h0 ##1 err_v == 2'h0 |-> mute_ch == '0) // RULE16
        else $error("mute held without error");
    a_wd_count: assert property (@(posedge clk_proc) disable iff (!presetn) // RULE13
        q_reg.en_s2 && q_reg.b_s2[0] == q_reg.b_q[0] && q_reg.wd[0] != SAPCC_WD_ZERO
        |=> q_reg.wd[0] == $past(q_reg.wd[0]) - 8'h01) else $error("watchdog did not count down");
    a_wd_reload: assert property (@(posedge clk_proc) disable iff (!presetn) // RULE14
        q_reg.en_s2 && q_reg.b_s2[1] != q_reg.b_q[1] |=> q_reg.wd[1] == SAPCC_WD_INIT && !q_reg.miss[1])
        else $error("watchdog not reloaded on edge");
    a_miss_flag: assert property (@(posedge clk_proc) disable iff (!presetn) // RULE15
        q_reg.en_s2 && q_reg.b_s2[0] == q_reg.b_q[0] && q_reg.wd[0] == SAPCC_WD_ZERO |=> q_reg.miss[0])
        else $error("missing clock not flagged");

    c_ratio_err: cover property ($rose(r_reg.p[0].rerr));
    c_miss_err: cover property ($rose(r_reg.ms2[1]));
    c_mute_on: cover property ($rose(mute_ch[0]));
    c_rx_word: cover property (stb_v[0] && $changed(r_reg.p[0].left));
endmodule : sapcc_top

// >>> core/sapcc_pkg.sv
// sapcc_pkg: register map, field layout and state types of the serial audio port
package sapcc_pkg;
    // Summary of operation
    // [RULE1] serial data and frame lines change only on the selected active bit-clock edge
    // [RULE2] receivers capture data and frame on the strobe edge, opposite the active edge
    // [RULE3] bit 7 of each port's edge/format register picks the rising or falling active edge
    // [RULE4] input and output ports run at independent sampling rates
    // [RULE5] master mode drives bit and frame clock pins from internal generators
    // [RULE6] slave mode takes bit and frame clocks from pins driven by the peripheral
    // [RULE7] word length is 8, 16, 24 or 32 bits
    // [RULE8] right, left justified, dsp, i2s and pcm delayed or non-delayed formats
    // [RULE9] clock checking watches only the serial inputs and mutes channels on a fault
    // [RULE10] check settings in bits 0 to 2 are shared, each input has its own checker
    // [RULE11] a fault mutes only the channels mapped to that input
    // [RULE12] ratio check compares bit clocks per frame with the programmed ratio
    // [RULE13] missing-clock watchdog is 8 bits, starts at ff, decrements each processing clock
    // [RULE14] every bit clock edge reloads the watchdog to ff
    // [RULE15] watchdog at zero flags a missing bit clock and mutes affected channels
    // [RULE16] mute releases once the check passes again, errors readable as status

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SAPCC_IN1_EFC = 8'h00;
    localparam logic [7:0] SAPCC_IN2_EFC = 8'h04;
    localparam logic [7:0] SAPCC_OUT_EFC = 8'h08;
    localparam logic [7:0] SAPCC_IN1_RATIO = 8'h0C;
    localparam logic [7:0] SAPCC_IN2_RATIO = 8'h10;
    localparam logic [7:0] SAPCC_OUT_RATIO = 8'h14;
    localparam logic [7:0] SAPCC_VALID_CFG = 8'h18;
    localparam logic [7:0] SAPCC_MODE = 8'h1C;
    localparam logic [7:0] SAPCC_MAP = 8'h20;
    localparam logic [7:0] SAPCC_TX_LEFT = 8'h24;
    localparam logic [7:0] SAPCC_TX_RIGHT = 8'h28;
    localparam logic [7:0] SAPCC_STATUS = 8'h2C;
    localparam logic [7:0] SAPCC_RX1_LEFT = 8'h30;
    localparam logic [7:0] SAPCC_RX1_RIGHT = 8'h34;
    localparam logic [7:0] SAPCC_RX2_LEFT = 8'h38;
    localparam logic [7:0] SAPCC_RX2_RIGHT = 8'h3C;

    // ------------------------------------------------------------
    // fields, codes and reset values
    // ------------------------------------------------------------
    localparam int SAPCC_EDGE_BIT = 7;
    localparam int SAPCC_WL_LSB = 0;
    localparam int SAPCC_FMT_LSB = 2;
    localparam int SAPCC_RATIO_EN = 0;
    localparam int SAPCC_MISS_EN = 1;
    localparam int SAPCC_MUTE_EN = 2;
    localparam int SAPCC_MODE_DIV_LSB = 8;
    localparam int SAPCC_NCH = 3;
    localparam logic [2:0] SAPCC_FMT_RJ = 3'h0;
    localparam logic [2:0] SAPCC_FMT_LJ = 3'h1;
    localparam logic [2:0] SAPCC_FMT_DSP = 3'h2;
    localparam logic [2:0] SAPCC_FMT_I2S = 3'h3;
    localparam logic [2:0] SAPCC_FMT_PCM_ND = 3'h4;
    localparam logic [2:0] SAPCC_FMT_PCM_D = 3'h5;
    localparam logic [1:0] SAPCC_MAP_IN1 = 2'h1;
    localparam logic [1:0] SAPCC_MAP_IN2 = 2'h2;
    localparam logic [7:0] SAPCC_WL_STEP = 8'h08;
    localparam logic [5:0] SAPCC_MAXW = 6'h20;
    localparam logic [7:0] SAPCC_RATIO_RST = 8'h40;
    localparam logic [7:0] SAPCC_DIV_RST = 8'h07;
    localparam logic [7:0] SAPCC_WD_INIT = 8'hFF;
    localparam logic [7:0] SAPCC_WD_ZERO = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SAPCC_IDLE = 2'b01, SAPCC_DONE = 2'b10} sapcc_apb_t;
    typedef logic [SAPCC_NCH-1:0][1:0] sapcc_map_t;

    typedef struct packed {
        logic b_s1, b_s2, f_s1, f_s2, d_s1, d_s2;
        logic bq, fq, gbclk, gfrm, rerr;
        logic [7:0] gdiv, gcnt, pos, per;
        logic [31:0] sh, left, right;
    } sapcc_port_t;

    typedef struct packed {
        sapcc_apb_t fsm;
        logic pready, pslverr;
        logic [31:0] prdata;
        logic [2:0][7:0] cfg;
        logic [2:0][7:0] ratio;
        logic [2:0] valid;
        logic master;
        logic [7:0] div;
        sapcc_map_t map;
        logic [31:0] txl, txr;
        sapcc_port_t [2:0] p;
        logic [1:0] ms1, ms2;
        logic [SAPCC_NCH-1:0] mute;
        logic sdo;
    } sapcc_st_t;

    typedef struct packed {
        logic [1:0] b_s1, b_s2, b_q, miss;
        logic [1:0][7:0] wd;
        logic en_s1, en_s2;
    } sapcc_pst_t;

    typedef struct packed {
        logic [2:0] bit_clock, bit_clock_oe, frame_clock, frame_clock_oe;
        logic serial_data_out;
    } sapcc_pins_t;
endpackage : sapcc_pkg

// >>> sim/sapcc_codec.sv
// sapcc_codec: behavioural slave-mode peripheral driving bit clock, frame clock and serial data
`timescale 1ns/10ps
module sapcc_codec (
    input wire logic run,
    input wire logic [7:0] half,
    input wire logic [31:0] word,
    output logic bclk,
    output logic lrclk,
    output logic sdata
);
    int n;
    // ----------------------------------------
    // clock generation, 200 ns bit period
    // ----------------------------------------
    initial begin
        bclk = 1'b0;
        lrclk = 1'b0;
        sdata = 1'b0;
        n = 0;
        forever begin
            #100;
            if (run) begin
                bclk = ~bclk;
                if (bclk) begin
                    // frame and data move on the rising active edge so the strobe edge sees them settled
                    n = (n + 1) % (2 * half);
                    lrclk = (n < half);
                    sdata = word[31 - (n % half)];
                end
            end else begin
                // stopped clock rests low; data is not held, so a stale level cannot pass for valid
                bclk = 1'b0;
                sdata = ~sdata;
            end
        end
    end
endmodule : sapcc_codec

// >>> sim/tb.sv
// tb: self-checking bench for the audio port clock checker with an apb master and two peripherals
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
    import sapcc_pkg::*;
    logic pclk, presetn, clk_proc, psel, penable, pwrite, run1, run2, e, bprev;
    logic [7:0] paddr, half1, half2;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr;
    logic [1:0] bc, fc, sd;
    sapcc_pins_t pins_o;
    logic [2:0] mute_ch;
    int fails, checked, cyc, mapv, err1, err2, tog;
    sapcc_top u_dut (.pclk(pclk), .presetn(presetn), .clk_proc(clk_proc), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bit_clock_i({1'b0, bc}), .frame_clock_i({1'b0, fc}), .serial_data_in(sd), .pins_o(pins_o),
        .mute_ch(mute_ch));
    sapcc_codec u_c1 (.run(run1), .half(half1), .word(32'ha5c3_0f96), .bclk(bc[0]), .lrclk(fc[0]), .sdata(sd[0]));
    sapcc_codec u_c2 (.run(run2), .half(half2), .word(32'h3c5a_f00f), .bclk(bc[1]), .lrclk(fc[1]), .sdata(sd[1]));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        clk_proc = 1'b0;
        #17;
        forever #62.5 clk_proc = ~clk_proc;
    end
    // ----------------------------------------
    // reference model of the mute outputs
    // ----------------------------------------
    function automatic logic [2:0] mexp();
        logic [2:0] m;
        for (int c = 0; c < 3; c++) begin
            m[c] = (((mapv >> (2 * c)) & 3) == 1 && err1 != 0) || (((mapv >> (2 * c)) & 3) == 2 && err2 != 0);
        end
        return m;
    endfunction : mexp
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (pready !== 1'b1) begin
            fails++;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic settle(input logic [2:0] x);
        int t;
        t = 0;
        while (mute_ch !== x && t < 20000) begin
            @(posedge pclk);
            t++;
        end
        `CHK("mute_ch", x, mute_ch)
    endtask : settle
    task automatic wait_sdo(input logic v);
        int t;
        t = 0;
        while (pins_o.serial_data_out !== v && t < 3000) begin
            @(posedge pclk);
            t++;
        end
        `CHK("serial_data_out", v, pins_o.serial_data_out)
    endtask : wait_sdo
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {run1, run2, half1, half2, fails, checked, cyc, mapv, err1, err2} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(32'hc3a5_480c));
        @(posedge pclk);
        apb(1'b0, SAPCC_IN2_RATIO, '0);
        `CHK("ratio reset", 32'h0000_0040, q)
        apb(1'b0, 8'h40, '0);
        `CHK("unmapped err", 1'b1, e)
        apb(1'b1, SAPCC_IN1_RATIO, 32'h0000_0040);
        apb(1'b1, SAPCC_IN1_EFC, 32'h0000_0001);
        apb(1'b1, SAPCC_IN2_EFC, 32'h0000_0004);
        apb(1'b1, SAPCC_VALID_CFG, 32'h0000_0007);
        mapv = 6'h19;
        apb(1'b1, SAPCC_MAP, mapv);
        {half1, half2, run1, run2} = {8'h20, 8'h20, 2'b11};
        settle(mexp());
        half2 = 8'h10;
        err2 = 1;
        settle(mexp());
        run1 = 1'b0;
        err1 = 1;
        settle(mexp());
        apb(1'b0, SAPCC_STATUS, '0);
        `CHK("status", 4'b0110, q[3:0])
        run1 = 1'b1;
        err1 = 0;
        settle(mexp());
        for (int i = 0; i < 4; i++) begin
            mapv = $urandom & 6'h3f;
            apb(1'b1, SAPCC_MAP, mapv);
            settle(mexp());
        end
        apb(1'b1, SAPCC_IN2_RATIO, 32'h0000_0020);
        err2 = 0;
        settle(mexp());
        // a whole frame of each input must close before the ratio flags are recomputed
        repeat (2000) @(posedge pclk);
        apb(1'b0, SAPCC_STATUS, '0);
        `CHK("status clear", 4'b0000, q[3:0])
        apb(1'b0, SAPCC_RX1_LEFT, '0);
        `CHK("rx1 left", 32'h0000_0f96, q)
        apb(1'b0, SAPCC_RX2_RIGHT, '0);
        `CHK("rx2 right", 32'h0000_003c, q)
        run2 = 1'b0;
        apb(1'b1, SAPCC_VALID_CFG, 32'h0000_0003);
        settle(3'b000);
        apb(1'b1, SAPCC_TX_LEFT, 32'hFFFF_FFFF);
        apb(1'b1, SAPCC_MODE, 32'h0000_0701);
        `CHK("bit_clock_oe", 3'h7, pins_o.bit_clock_oe)
        bprev = pins_o.bit_clock[2];
        tog = 0;
        repeat (64) begin
            @(posedge pclk);
            if (pins_o.bit_clock[2] !== bprev) begin
                tog++;
            end
            bprev = pins_o.bit_clock[2];
        end
        `CHK("bit clock toggles", 8, tog)
        wait_sdo(1'b1);
        wait_sdo(1'b0);
        complete_run();
    end
endmodule : tb
